// >>> wrsr_regs.sv
// Status and setpoint registers of the wireless power receiver.
// Assumes requests and measurements come from logic on mclk.
`timescale 1ns/1ps

module wrsr_regs
  import wrsr_pkg::*;
#(
  parameter int ADC_BITS = WRSR_ADC_BITS  // Converter code width
) (
  input  wire logic       mclk,           // 20 MHz clock
  input  wire logic       reset_n,        // Async reset, active low
  input  wire wrsr_req_s  req,            // Byte register request
  output logic [7:0]      rdata,          // Read byte, registered
  output logic            rvalid,         // Read data valid pulse
  input  wire wrsr_meas_s meas,           // Live measurements
  input  wire logic       tx_mode,        // High while transmitting
  output logic [7:0]      charge_status_payload, // Charge packet payload
  output logic [7:0]      end_transfer_reason,   // End packet code
  output logic [15:0]     vout_setpoint,  // Output regulator setpoint
  output logic            rect_retarget   // Pulse: retarget rectifier
);

  // Codes wider than the register cannot be served
  if (ADC_BITS < 1 || ADC_BITS > 16) begin : g_width_check
    $error("ADC_BITS must lie in 1..16");
  end

  localparam logic [16:0] ADC_ONE  = 17'h00001;
  localparam logic [15:0] ADC_MASK = 16'((ADC_ONE << ADC_BITS) - ADC_ONE);

  logic [7:0]  chg_reg;
  logic [7:0]  rsn_reg;
  logic [15:0] set_reg;
  logic [7:0]  set_lo_stage_reg;
  logic [7:0]  hi_shadow_reg;
  logic [7:0]  rdata_reg;
  logic        rvalid_reg;
  logic        retarget_reg;

  // Measurement words, masked to the converter width except the current word
  wire logic [15:0] vout_val  = meas.vout & ADC_MASK;
  wire logic [15:0] vrect_val = meas.vrect & ADC_MASK;
  wire logic [15:0] ntc_val   = {4'h0, meas.ntc[11:0]} & ADC_MASK;
  wire logic [15:0] cur_val   = tx_mode ? meas.iin : meas.iout;
  wire logic [15:0] die_val   = meas.die & ADC_MASK;

  // Write decode
  wire logic wr_chg    = req.wr && (req.addr == WRSR_CHG_STAT_ADDR);
  wire logic wr_rsn    = req.wr && (req.addr == WRSR_END_RSN_ADDR);
  wire logic wr_set_lo = req.wr && (req.addr == WRSR_VOUT_SET_ADDR);
  wire logic wr_set_hi = req.wr && (req.addr == WRSR_VOUT_SET_ADDR + 8'h01);

  // Read selection; a low-byte read also yields the high byte to shadow
  logic [7:0] rd_byte;
  logic [7:0] rd_hi;
  logic       rd_lo_pair;
  always_comb begin
    rd_byte    = WRSR_UNMAPPED_RD;
    rd_hi      = 8'h00;
    rd_lo_pair = 1'b0;
    case (req.addr)
      WRSR_ALIGN_X_ADDR:  rd_byte = meas.align_x;
      WRSR_ALIGN_Y_ADDR:  rd_byte = meas.align_y;
      WRSR_CHG_STAT_ADDR: rd_byte = chg_reg;
      WRSR_END_RSN_ADDR:  rd_byte = rsn_reg;
      WRSR_VOUT_RD_ADDR: begin
        rd_byte    = vout_val[7:0];
        rd_hi      = vout_val[15:8];
        rd_lo_pair = 1'b1;
      end
      WRSR_VOUT_SET_ADDR: begin
        rd_byte    = set_reg[7:0];
        rd_hi      = set_reg[15:8];
        rd_lo_pair = 1'b1;
      end
      WRSR_VRECT_RD_ADDR: begin
        rd_byte    = vrect_val[7:0];
        rd_hi      = vrect_val[15:8];
        rd_lo_pair = 1'b1;
      end
      WRSR_NTC_RD_ADDR: begin
        rd_byte    = ntc_val[7:0];
        rd_hi      = ntc_val[15:8];
        rd_lo_pair = 1'b1;
      end
      WRSR_CUR_RD_ADDR: begin
        rd_byte    = cur_val[7:0];
        rd_hi      = cur_val[15:8];
        rd_lo_pair = 1'b1;
      end
      WRSR_DIE_RD_ADDR: begin
        rd_byte    = die_val[7:0];
        rd_hi      = die_val[15:8];
        rd_lo_pair = 1'b1;
      end
      WRSR_VOUT_RD_ADDR + 8'h01,
      WRSR_VOUT_SET_ADDR + 8'h01,
      WRSR_VRECT_RD_ADDR + 8'h01,
      WRSR_NTC_RD_ADDR + 8'h01,
      WRSR_CUR_RD_ADDR + 8'h01,
      WRSR_DIE_RD_ADDR + 8'h01: rd_byte = hi_shadow_reg;
      default: rd_byte = WRSR_UNMAPPED_RD;
    endcase
  end

  // Host-written bytes; held exactly as written
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      chg_reg <= WRSR_CHG_STAT_RST;
      rsn_reg <= WRSR_END_RSN_RST;
    end else begin
      if (wr_chg) chg_reg <= req.wdata;
      if (wr_rsn) rsn_reg <= req.wdata;
    end
  end

  // Setpoint commits on the high byte so the regulator never sees half a word
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      set_lo_stage_reg <= WRSR_VOUT_SET_RST[7:0];
      set_reg          <= WRSR_VOUT_SET_RST;
      retarget_reg     <= 1'b0;
    end else begin
      if (wr_set_lo) set_lo_stage_reg <= req.wdata;
      if (wr_set_hi) set_reg <= {req.wdata, set_lo_stage_reg};
      retarget_reg <= wr_set_hi;
    end
  end

  // Read port; high byte is frozen at the low-byte read to avoid tearing
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg     <= 8'h00;
      rvalid_reg    <= 1'b0;
      hi_shadow_reg <= 8'h00;
    end else begin
      rvalid_reg <= req.rd;
      if (req.rd) rdata_reg <= rd_byte;
      if (req.rd && rd_lo_pair) hi_shadow_reg <= rd_hi;
    end
  end

  assign rdata                 = rdata_reg;
  assign rvalid                = rvalid_reg;
  assign charge_status_payload = chg_reg;
  assign end_transfer_reason   = rsn_reg;
  assign vout_setpoint         = set_reg;
  assign rect_retarget         = retarget_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  wire logic rd_at_y = req.rd && (req.addr == WRSR_ALIGN_Y_ADDR);
  wire logic rd_at_x = req.rd && (req.addr == WRSR_ALIGN_X_ADDR);

  align_y_read_a: assert property (rd_at_y |=> rvalid && rdata == $past(meas.align_y))
    else $error("Y alignment read wrong");
  align_x_read_a: assert property (rd_at_x |=> rvalid && rdata == $past(meas.align_x))
    else $error("X alignment read wrong");
  payload_hold_a: assert property (!wr_chg |=> $stable(charge_status_payload))
    else $error("Charge payload changed without write");
  payload_pass_a: assert property (wr_chg |=> charge_status_payload == $past(req.wdata))
    else $error("Charge payload not passed unchanged");
  reason_pass_a: assert property (wr_rsn ##1 !wr_rsn |=> end_transfer_reason == $past(req.wdata, 2))
    else $error("End reason not held as written");
  vout_read_a: assert property (req.rd && req.addr == WRSR_VOUT_RD_ADDR
                                |=> rdata == $past(vout_val[7:0]))
    else $error("Output voltage low byte wrong");
  setpoint_commit_a: assert property (wr_set_lo ##1 wr_set_hi
                                      |=> rect_retarget && vout_setpoint == {$past(req.wdata), $past(req.wdata, 2)})
    else $error("Setpoint commit or retarget wrong");
  retarget_cause_a: assert property (rect_retarget |-> $past(wr_set_hi))
    else $error("Retarget without setpoint write");
  vrect_read_a: assert property (req.rd && req.addr == WRSR_VRECT_RD_ADDR
                                 |=> rdata == $past(vrect_val[7:0]))
    else $error("Rectified voltage low byte wrong");
  ntc_top_zero_a: assert property (req.rd && req.addr == WRSR_NTC_RD_ADDR ##1 !req.rd ##1
                                   req.rd && req.addr == WRSR_NTC_RD_ADDR + 8'h01
                                   |=> rdata[7:4] == 4'h0)
    else $error("Thermistor reserved bits not zero");
  current_mode_a: assert property (req.rd && req.addr == WRSR_CUR_RD_ADDR
                                   |=> rdata == ($past(tx_mode) ? $past(meas.iin[7:0]) : $past(meas.iout[7:0])))
    else $error("Current register source wrong");
  die_pair_a: assert property (req.rd && req.addr == WRSR_DIE_RD_ADDR ##1 !req.rd ##1
                               req.rd && req.addr == WRSR_DIE_RD_ADDR + 8'h01
                               |=> rdata == $past(die_val[15:8], 3))
    else $error("Die temperature high byte wrong");

  // Read port timing: exactly one valid pulse per read strobe
  rvalid_pulse_a: assert property (req.rd |=> rvalid)
    else $error("Read without valid pulse");

  // No valid pulse without a read strobe
  rvalid_only_a: assert property (!req.rd |=> !rvalid)
    else $error("Valid pulse without read");

  // Read data stands until the next read
  rdata_hold_a: assert property (!req.rd |=> $stable(rdata))
    else $error("Read data changed without read");

  // Payload register reads back what was written
  chg_read_a: assert property (req.rd && req.addr == WRSR_CHG_STAT_ADDR
                               |=> rdata == $past(charge_status_payload))
    else $error("Charge payload readback wrong");

  // End reason register reads back what was written
  reason_read_a: assert property (req.rd && req.addr == WRSR_END_RSN_ADDR
                                  |=> rdata == $past(end_transfer_reason))
    else $error("End reason readback wrong");

  // End reason changes only on its own write
  reason_hold_a: assert property (!wr_rsn |=> $stable(end_transfer_reason))
    else $error("End reason changed without write");

  // Setpoint changes only on a high-byte write
  setpoint_hold_a: assert property (!wr_set_hi |=> $stable(vout_setpoint))
    else $error("Setpoint changed without commit");

  // Low byte alone is only staged
  stage_only_a: assert property (wr_set_lo |=> $stable(vout_setpoint) && !rect_retarget)
    else $error("Low setpoint byte took effect");

  // Every commit retargets the rectifier
  retarget_pulse_a: assert property (wr_set_hi |=> rect_retarget)
    else $error("Commit without retarget pulse");

  // Retarget lasts one cycle unless another commit follows
  retarget_single_a: assert property (!wr_set_hi |=> !rect_retarget)
    else $error("Retarget pulse too long");

  // Unmapped space reads as zero
  unmapped_read_a: assert property (req.rd && req.addr > WRSR_DIE_RD_ADDR + 8'h01
                                    |=> rvalid && rdata == WRSR_UNMAPPED_RD)
    else $error("Unmapped read not zero");

  // Writes to read-only bytes leave host registers alone
  ro_write_a: assert property (req.wr && req.addr == WRSR_ALIGN_Y_ADDR
                               |=> $stable(charge_status_payload) && $stable(end_transfer_reason)
                                   && $stable(vout_setpoint))
    else $error("Read-only write had an effect");

  // Setpoint low byte readback
  setpoint_read_a: assert property (req.rd && req.addr == WRSR_VOUT_SET_ADDR
                                    |=> rdata == $past(vout_setpoint[7:0]))
    else $error("Setpoint low byte readback wrong");

  // Thermistor low byte is the raw code
  ntc_low_a: assert property (req.rd && req.addr == WRSR_NTC_RD_ADDR
                              |=> rdata == $past(meas.ntc[7:0]))
    else $error("Thermistor low byte wrong");

  // Die temperature low byte
  die_low_a: assert property (req.rd && req.addr == WRSR_DIE_RD_ADDR
                              |=> rdata == $past(die_val[7:0]))
    else $error("Die temperature low byte wrong");

  // Output voltage high byte comes from the low-byte sample
  vout_pair_a: assert property (req.rd && req.addr == WRSR_VOUT_RD_ADDR ##1 !req.rd ##1
                                req.rd && req.addr == WRSR_VOUT_RD_ADDR + 8'h01
                                |=> rdata == $past(vout_val[15:8], 3))
    else $error("Output voltage high byte wrong");

  // Output voltage code bits above the converter width read as zero
  vout_top_zero_a: assert property (req.rd && req.addr == WRSR_VOUT_RD_ADDR ##1 !req.rd ##1
                                    req.rd && req.addr == WRSR_VOUT_RD_ADDR + 8'h01
                                    |=> (rdata & ~ADC_MASK[15:8]) == 8'h00)
    else $error("Output voltage top bits not zero");

  // Rectified voltage high byte from the same sample
  vrect_pair_a: assert property (req.rd && req.addr == WRSR_VRECT_RD_ADDR ##1 !req.rd ##1
                                 req.rd && req.addr == WRSR_VRECT_RD_ADDR + 8'h01
                                 |=> rdata == $past(vrect_val[15:8], 3))
    else $error("Rectified voltage high byte wrong");

  // Rectified voltage keeps only the converter bits
  vrect_top_zero_a: assert property (req.rd && req.addr == WRSR_VRECT_RD_ADDR ##1 !req.rd ##1
                                     req.rd && req.addr == WRSR_VRECT_RD_ADDR + 8'h01
                                     |=> (rdata & ~ADC_MASK[15:8]) == 8'h00)
    else $error("Rectified voltage top bits not zero");

  // Current high byte follows the mode at the low-byte read
  current_pair_a: assert property (req.rd && req.addr == WRSR_CUR_RD_ADDR ##1 !req.rd ##1
                                   req.rd && req.addr == WRSR_CUR_RD_ADDR + 8'h01
                                   |=> rdata == ($past(tx_mode, 3) ? $past(meas.iin[15:8], 3)
                                                                   : $past(meas.iout[15:8], 3)))
    else $error("Current high byte wrong");

  // Setpoint high byte readback
  setpoint_pair_a: assert property (req.rd && req.addr == WRSR_VOUT_SET_ADDR ##1 !req.rd ##1
                                    req.rd && req.addr == WRSR_VOUT_SET_ADDR + 8'h01
                                    |=> rdata == $past(vout_setpoint[15:8], 3))
    else $error("Setpoint high byte readback wrong");

  // Alignment reads always answer
  align_valid_a: assert property (rd_at_x || rd_at_y |=> rvalid)
    else $error("Alignment read without valid");

endmodule : wrsr_regs

// >>> wrsr_pkg.sv
// Package for the wireless receiver status register group.
// Assumes a byte-wide register port on the host interface clock.
package wrsr_pkg;

  // Byte offsets of the register group
  localparam logic [7:0] WRSR_ALIGN_X_ADDR   = 8'h38;
  localparam logic [7:0] WRSR_ALIGN_Y_ADDR   = 8'h39;
  localparam logic [7:0] WRSR_CHG_STAT_ADDR  = 8'h3a;
  localparam logic [7:0] WRSR_END_RSN_ADDR   = 8'h3b;
  localparam logic [7:0] WRSR_VOUT_RD_ADDR   = 8'h3c;
  localparam logic [7:0] WRSR_VOUT_SET_ADDR  = 8'h3e;
  localparam logic [7:0] WRSR_VRECT_RD_ADDR  = 8'h40;
  localparam logic [7:0] WRSR_NTC_RD_ADDR    = 8'h42;
  localparam logic [7:0] WRSR_CUR_RD_ADDR    = 8'h44;
  localparam logic [7:0] WRSR_DIE_RD_ADDR    = 8'h46;

  // Reset values and the value read from unmapped space
  localparam logic [7:0]  WRSR_CHG_STAT_RST = 8'h00;
  localparam logic [7:0]  WRSR_END_RSN_RST  = 8'h00;
  localparam logic [15:0] WRSR_VOUT_SET_RST = 16'h0000;
  localparam logic [7:0]  WRSR_UNMAPPED_RD  = 8'h00;

  // Documented ADC code width
  localparam int WRSR_ADC_BITS = 12;

  // End of power transfer reasons
  localparam logic [7:0] WRSR_EOPT_UNKNOWN  = 8'h00;
  localparam logic [7:0] WRSR_EOPT_END_CHG  = 8'h01;
  localparam logic [7:0] WRSR_EOPT_FAULT    = 8'h02;
  localparam logic [7:0] WRSR_EOPT_OVERTEMP = 8'h03;
  localparam logic [7:0] WRSR_EOPT_OVERVOLT = 8'h05;
  localparam logic [7:0] WRSR_EOPT_RECONFIG = 8'h06;
  localparam logic [7:0] WRSR_EOPT_NO_RESP  = 8'h08;

  // Charge status payload markers
  localparam logic [7:0] WRSR_CHG_NONE = 8'hff;

  // Host wait between command writes, in milliseconds
  localparam int WRSR_CMD_WAIT_MIN_MS = 3;

  // Byte register request from the host side
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wrsr_req_s;

  // Live measurements from the converter sequencer
  typedef struct packed {
    logic [7:0]  align_x;
    logic [7:0]  align_y;
    logic [15:0] vout;
    logic [15:0] vrect;
    logic [15:0] ntc;
    logic [15:0] iout;
    logic [15:0] iin;
    logic [15:0] die;
  } wrsr_meas_s;

endpackage : wrsr_pkg

// >>> wrsr_host.sv
// Host processor model for the status register byte port.
// Assumes the port takes strobes on the rising mclk edge.
`timescale 1ns/1ps

module wrsr_host
  import wrsr_pkg::*;
(
  input  wire logic       mclk,   // Port clock
  output wrsr_req_s       req,    // Byte request
  input  wire logic [7:0] rdata,  // Read byte
  input  wire logic       rvalid  // Read valid pulse
);
  // Idle port at time zero
  initial req = '0;

  // Released lines show the inverse, so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk) req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    #1;
  endtask : wr

  // Back-to-back low then high byte, so the commit follows the staging at once
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk) req <= '{addr: a, wdata: d[7:0], wr: 1'b1, rd: 1'b0};
    @(posedge mclk) req <= '{addr: a + 8'h01, wdata: d[15:8], wr: 1'b1, rd: 1'b0};
    @(posedge mclk) req <= '{addr: ~a, wdata: ~d[15:8], wr: 1'b0, rd: 1'b0};
    #1;
  endtask : wr16

  // Data without its valid pulse is returned as unknown
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk) req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    #1;
    d = (rvalid === 1'b1) ? rdata : 8'hxx;
  endtask : rd

  // Low byte first so the high byte comes from the same sample
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 8'h01, d[15:8]);
  endtask : rd16
  // Command register pacing lies outside this port
endmodule : wrsr_host

// >>> tb_wrsr.sv
// Self-checking bench for the receiver status register group.
// Assumes wrsr_regs with default ADC_BITS of 12.
`timescale 1ns/1ps

module testbench;
  import wrsr_pkg::*;
  logic       mclk, reset_n, tx_mode, rvalid, retarget;
  wrsr_req_s  req;
  wrsr_meas_s meas;
  logic [7:0] rdata, payload, reason, b;
  logic [15:0] setp, v;
  int         err_total, checks, cycles;
  logic [7:0] codes [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09, 8'hfe};

  wrsr_regs DUT (.mclk(mclk), .reset_n(reset_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .meas(meas), .tx_mode(tx_mode), .charge_status_payload(payload), .end_transfer_reason(reason),
    .vout_setpoint(setp), .rect_retarget(retarget));
  wrsr_host HOST (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // Clock at 20 MHz
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Hang guard, well above the fewer than one hundred cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    reset_n = 1'b0; tx_mode = 1'b0; meas = '0; err_total = 0; checks = 0; cycles = 0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    chk({payload, reason}, 16'h0000);
    HOST.rd(8'h3a, b); chk({8'h00, b}, 16'h0000);
    HOST.rd(8'h3b, b); chk({8'h00, b}, 16'h0000);
    @(posedge mclk) meas <= '{8'h85, 8'h7f, 16'hfabc, 16'h1fff, 16'hffff, 16'h8765, 16'h0321, 16'h1234};
    HOST.rd(8'h38, b); chk({8'h00, b}, 16'h0085);
    HOST.rd(8'h39, b); chk({8'h00, b}, 16'h007f);
    HOST.rd16(8'h3c, v); chk(v, 16'h0abc);
    HOST.rd16(8'h40, v); chk(v, 16'h0fff);
    HOST.rd16(8'h42, v); chk(v, 16'h0fff);
    HOST.rd16(8'h44, v); chk(v, 16'h8765);
    @(posedge mclk) tx_mode <= 1'b1;
    HOST.rd16(8'h44, v); chk(v, 16'h0321);
    HOST.rd16(8'h46, v); chk(v, 16'h0234);
    HOST.wr(8'h3a, 8'h64); chk({8'h00, payload}, 16'h0064);
    HOST.wr(8'h3a, WRSR_CHG_NONE); HOST.rd(8'h3a, b); chk({payload, b}, 16'hffff);
    foreach (codes[i]) begin
      HOST.wr(8'h3b, codes[i]); chk({8'h00, reason}, {8'h00, codes[i]});
    end
    HOST.wr(8'h39, 8'h00); HOST.rd(8'h39, b); chk({8'h00, b}, 16'h007f);
    HOST.wr(8'h50, 8'haa); HOST.rd(8'h50, b); chk({8'h00, b}, 16'h0000);
    // 5000 mV gives (5000-2800)*10/84 = 0x0105
    HOST.wr(8'h3e, 8'h05); chk(setp, 16'h0000);
    HOST.wr(8'h3f, 8'h01); chk({15'h0000, retarget}, 16'h0001);
    chk(setp, 16'h0105);
    @(posedge mclk) #1 chk({15'h0000, retarget}, 16'h0000);
    HOST.rd16(8'h3e, v); chk(v, 16'h0105);
    // 12000 mV gives (12000-2800)*10/84 = 0x0447
    HOST.wr16(8'h3e, 16'h0447); chk({15'h0000, retarget}, 16'h0001);
    chk(setp, 16'h0447);
    HOST.rd16(8'h3e, v); chk(v, 16'h0447);
    test_done();
  end
endmodule : testbench
